// ==== inc/pfs_pkg.sv ====
// package for the port A pin function select block
// assumes an APB master with 32-bit data and one clock
package pfs_pkg;
   localparam logic [11:0] FUNC_SEL_OFFSET = 12'h000;
   localparam logic [31:0] FUNC_SEL_RESET = 32'h00000000;
   localparam int PIN_COUNT = 15;
   localparam int FIELD_WIDTH = 2;
   localparam logic [31:0] FUNC_SEL_WRITABLE = 32'h3FFFFFFF;
   localparam logic [1:0] MODE_INPUT = 2'h0;
   localparam logic [1:0] MODE_OUTPUT = 2'h1;
   localparam logic [1:0] MODE_RESERVED = 2'h2;
   localparam logic [1:0] MODE_ALTERNATE = 2'h3;
endpackage : pfs_pkg

// ==== src/pfs_pin_cell.sv ====
// one pin of the port: decodes its mode field and steers the pad
// assumes the mode field comes from the function select register
`timescale 1ns/100ps
`default_nettype none
module pfs_pin_cell (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [1:0] mode_i,
   input wire logic port_out_i,
   input wire logic alt_out_i,
   input wire logic alt_oe_i,
   input wire logic pad_in_i,
   output logic pad_out_o,
   output logic pad_oe_o,
   output logic port_in_o,
   output logic alt_in_o
);
   logic nxt_pad_out;
   logic nxt_pad_oe;
   logic nxt_port_in;
   logic nxt_alt_in;
   logic pad_out_ff;
   logic pad_oe_ff;
   logic port_in_ff;
   logic alt_in_ff;

   // mode decode; reserved code keeps the pin as a safe input
   always_comb begin
      nxt_pad_out = 1'b0;
      nxt_pad_oe = 1'b0;
      nxt_port_in = pad_in_i;
      nxt_alt_in = 1'b0;
      unique case (mode_i)
         pfs_pkg::MODE_OUTPUT: begin
            nxt_pad_out = port_out_i;
            nxt_pad_oe = 1'b1;
         end
         pfs_pkg::MODE_ALTERNATE: begin
            nxt_pad_out = alt_out_i;
            nxt_pad_oe = alt_oe_i;
            nxt_alt_in = pad_in_i;
         end
         default: begin
            nxt_pad_out = 1'b0; // input, or reserved code
         end
      endcase
   end

   // pad registers; data path, so the system reset also clears them
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pad_out_ff <= 1'b0;
         pad_oe_ff <= 1'b0;
         port_in_ff <= 1'b0;
         alt_in_ff <= 1'b0;
      end else begin
         pad_out_ff <= nxt_pad_out;
         pad_oe_ff <= nxt_pad_oe;
         port_in_ff <= nxt_port_in;
         alt_in_ff <= nxt_alt_in;
      end
   end

   assign pad_out_o = pad_out_ff;
   assign pad_oe_o = pad_oe_ff;
   assign port_in_o = port_in_ff;
   assign alt_in_o = alt_in_ff;

   a_output_drives: assert property (@(posedge clk_i) disable iff (srst_i)
      mode_i == pfs_pkg::MODE_OUTPUT |=> pad_oe_ff && pad_out_ff == $past(port_out_i))
      else $error("output mode pad drive wrong");
   a_input_floats: assert property (@(posedge clk_i) disable iff (srst_i)
      mode_i == pfs_pkg::MODE_INPUT |=> !pad_oe_ff && port_in_ff == $past(pad_in_i))
      else $error("input mode pad not released");
   a_alt_routes: assert property (@(posedge clk_i) disable iff (srst_i)
      mode_i == pfs_pkg::MODE_ALTERNATE |=>
      pad_oe_ff == $past(alt_oe_i) && pad_out_ff == $past(alt_out_i))
      else $error("alternate mode routing wrong");
endmodule : pfs_pin_cell
`default_nettype wire

// ==== src/pfs_port_a.sv ====
// port A pin function select: APB register and per-pin pad steering
// assumes APB master on CLK_I; PORST_I is power-on reset, SRST_I any reset
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module pfs_port_a #(
   parameter int PINS = pfs_pkg::PIN_COUNT
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic PORST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [PINS-1:0] PORT_OUT_I,
   output logic [PINS-1:0] PORT_IN_O,
   input wire logic [PINS-1:0] ALT_OUT_I,
   input wire logic [PINS-1:0] ALT_OE_I,
   output logic [PINS-1:0] ALT_IN_O,
   input wire logic [PINS-1:0] PAD_IN_I,
   output logic [PINS-1:0] PAD_OUT_O,
   output logic [PINS-1:0] PAD_OE_O
);
   logic [31:0] func_sel_ff;
   logic [31:0] nxt_func_sel;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic pready_ff;
   logic nxt_pready;
   logic pslverr_ff;
   logic nxt_pslverr;
   logic setup;
   logic hit;

   // byte-lane merge of write data under strobes
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   // slave answers one cycle after setup: no wait state
   assign setup = PSEL_I && !PENABLE_I;
   assign hit = (PADDR_I == pfs_pkg::FUNC_SEL_OFFSET);

   // register next value; write lands at the setup edge's follower
   always_comb begin
      nxt_func_sel = func_sel_ff;
      nxt_pready = 1'b0;
      nxt_pslverr = 1'b0;
      nxt_prdata = 32'h00000000;
      if (setup) begin
         nxt_pready = 1'b1;
         nxt_pslverr = !hit;
         if (hit && PWRITE_I) begin
            nxt_func_sel = merge_bytes(func_sel_ff, PWDATA_I, PSTRB_I)
               & pfs_pkg::FUNC_SEL_WRITABLE;
         end else if (hit) begin
            nxt_prdata = func_sel_ff & pfs_pkg::FUNC_SEL_WRITABLE;
         end
      end
   end

   // function select ignores SRST_I, so writes still land under it; only PORST_I clears it
   always_ff @(posedge CLK_I) begin
      if (PORST_I) begin
         func_sel_ff <= pfs_pkg::FUNC_SEL_RESET;
      end else if (PREADY_O || !setup) begin
         func_sel_ff <= func_sel_ff;
      end else begin
         func_sel_ff <= nxt_func_sel;
      end
   end

   // bus answer registers
   always_ff @(posedge CLK_I) begin
      if (SRST_I || PORST_I) begin
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign PRDATA_O = prdata_ff;
   assign PREADY_O = pready_ff;
   assign PSLVERR_O = pslverr_ff;

   // one pin cell per two-bit field
   for (genvar n = 0; n < PINS; n++) begin : g_pin
      pfs_pin_cell u_cell (
         .clk_i(CLK_I),
         .srst_i(SRST_I || PORST_I),
         .mode_i(func_sel_ff[2*n +: 2]),
         .port_out_i(PORT_OUT_I[n]),
         .alt_out_i(ALT_OUT_I[n]),
         .alt_oe_i(ALT_OE_I[n]),
         .pad_in_i(PAD_IN_I[n]),
         .pad_out_o(PAD_OUT_O[n]),
         .pad_oe_o(PAD_OE_O[n]),
         .port_in_o(PORT_IN_O[n]),
         .alt_in_o(ALT_IN_O[n])
      );
   end

   sequence s_write_taken;
      PSEL_I && !PENABLE_I && PWRITE_I && hit && PSTRB_I == 4'hF;
   endsequence

   a_write_stores: assert property (@(posedge CLK_I) disable iff (PORST_I)
      s_write_taken |=> func_sel_ff == ($past(PWDATA_I) & pfs_pkg::FUNC_SEL_WRITABLE))
      else $error("write not stored");
   a_por_clears: assert property (@(posedge CLK_I)
      PORST_I |=> func_sel_ff == pfs_pkg::FUNC_SEL_RESET)
      else $error("power-on reset did not clear");
   a_srst_keeps: assert property (@(posedge CLK_I) disable iff (PORST_I)
      SRST_I && !setup |=> $stable(func_sel_ff))
      else $error("register lost under reset");
   a_reserved_zero: assert property (@(posedge CLK_I) disable iff (PORST_I)
      func_sel_ff[31:30] == 2'h0 && PRDATA_O[31:30] == 2'h0)
      else $error("reserved bits not zero");
   a_answer_timing: assert property (@(posedge CLK_I) disable iff (SRST_I || PORST_I)
      setup |=> PREADY_O ##1 !PREADY_O)
      else $error("bus answer timing wrong");
   a_read_value: assert property (@(posedge CLK_I) disable iff (SRST_I || PORST_I)
      setup && hit && !PWRITE_I |=> PRDATA_O == $past(func_sel_ff))
      else $error("read data wrong");
endmodule : pfs_port_a
`default_nettype wire

// ==== verification/pfs_pad_model.sv ====
// board side of the port A pins
// assumes the block's registered pad drive and enable
`timescale 1ns/100ps
`default_nettype none
module pfs_pad_model #(
   parameter int PINS = 15
) (
   input wire logic [PINS-1:0] drive_i,
   input wire logic [PINS-1:0] drive_oe_i,
   input wire logic [PINS-1:0] board_i,
   output logic [PINS-1:0] level_o
);
   // driven pins follow the block, idle pins show the board level
   assign level_o = (drive_oe_i & drive_i) | (~drive_oe_i & board_i);
endmodule : pfs_pad_model
`default_nettype wire

// ==== verification/port_a_pin_function_select_test.sv ====
// self-checking bench for the port A function select block
// assumes the APB slave answers with one access cycle
`timescale 1ns/100ps
`default_nettype none
module port_a_pin_function_select_test;
   logic clk = 1'h0, srst = 1'h1, porst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
   logic pready, pslverr, lasterr;
   logic [11:0] paddr = 12'h000;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [14:0] pout = 15'h2AAA, aout = 15'h5555, aoe = 15'h7FFF, board = 15'h7FFF;
   logic [14:0] pin, ain, lvl, dout, doe;
   int errors = 0, samples_checked = 0;
   initial forever #10 clk = ~clk;
   pfs_port_a u_dut (.CLK_I(clk), .SRST_I(srst), .PORST_I(porst), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PORT_OUT_I(pout),
      .PORT_IN_O(pin), .ALT_OUT_I(aout), .ALT_OE_I(aoe), .ALT_IN_O(ain), .PAD_IN_I(lvl),
      .PAD_OUT_O(dout), .PAD_OE_O(doe));
   pfs_pad_model u_pads (.drive_i(dout), .drive_oe_i(doe), .board_i(board), .level_o(lvl));
   task check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // one APB transfer; request held until pready is seen at an edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwr <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      lasterr = pslverr;
      if (n >= 20) errors++;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask : apb
   task hold_reset(input logic por);
      @(posedge clk);
      srst <= 1'h1;
      porst <= por;
      repeat (4) @(posedge clk);
      srst <= 1'h0;
      porst <= 1'h0;
   endtask : hold_reset
   task t_access;
      apb(1'h0, 12'h000, 32'h0);
      check(rd, 32'h0);
      apb(1'h1, 12'h000, 32'h3FFFFFFF);
      apb(1'h0, 12'h000, 32'h0);
      check(rd, 32'h3FFFFFFF);
      pstrb <= 4'h1;
      apb(1'h1, 12'h000, 32'h00000000);
      pstrb <= 4'hF;
      apb(1'h0, 12'h000, 32'h0);
      check(rd, 32'h3FFFFF00);
      apb(1'h0, 12'h004, 32'h0);
      check({31'h0, lasterr}, 32'h1);
      check(rd, 32'h0);
   endtask : t_access
   task t_keep;
      apb(1'h1, 12'h000, 32'h1C3D5F74);
      hold_reset(1'h0);
      apb(1'h0, 12'h000, 32'h0);
      check(rd, 32'h1C3D5F74);
      hold_reset(1'h1);
      apb(1'h0, 12'h000, 32'h0);
      check(rd, 32'h0);
   endtask : t_keep
   // pins cycle through input, output, alternate; reserved code never used
   task t_modes(input logic [14:0] brd);
      logic [31:0] cfg;
      logic [14:0] eoe, eout, elvl, eain;
      cfg = 32'h0;
      for (int n = 0; n < 15; n++) begin
         cfg[2*n +: 2] = (n % 3 == 0) ? 2'h0 : (n % 3 == 1) ? 2'h1 : 2'h3;
         eoe[n] = (n % 3 == 1) ? 1'h1 : (n % 3 == 2) ? aoe[n] : 1'h0;
         eout[n] = (n % 3 == 1) ? pout[n] : aout[n];
         elvl[n] = eoe[n] ? eout[n] : brd[n];
         eain[n] = (n % 3 == 2) ? elvl[n] : 1'h0;
      end
      board <= brd;
      apb(1'h1, 12'h000, cfg);
      repeat (4) @(posedge clk);
      check({17'h0, doe}, {17'h0, eoe});
      check({17'h0, dout & doe}, {17'h0, eout & eoe});
      check({17'h0, pin}, {17'h0, elvl});
      check({17'h0, ain}, {17'h0, eain});
   endtask : t_modes
   task wrap_up;
      if (errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #100us;
      errors++;
      wrap_up();
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'h0;
      porst <= 1'h0;
      t_access();
      t_keep();
      t_modes(15'h7FFF);
      t_modes(15'h0000);
      wrap_up();
   end
endmodule : port_a_pin_function_select_test
`default_nettype wire
